// >>> rtl/lcd_video_timing_status.sv
// Video timing generator with status, sync interrupts and colour/cursor tables on AHB-Lite.
`timescale 1ns/1ps
`include "lvt_map.svh"
module lcd_video_timing_status
  import lvt_pkg::*;
#(
  parameter int CW = 11
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel pins
  output lvt_sync_s panelPins,
  output logic pixelClockInvert,
  // Interrupt requests
  output logic lineIrq,
  output logic frameIrq,
  // Cursor pattern lookup for the overlay path
  input wire logic [4:0] cursorX,
  input wire logic [4:0] cursorY,
  output logic [3:0] cursorPixel
);

  logic [31:0] modeReg, irqCtl;
  logic [CW-1:0] activeWidth, activeHeight;
  logic [CW-1:0] hFront, hBlank, hTotal, vFront, vBlank, vTotal;
  logic [31:0] colorTable [256];
  logic [31:0] cursorPattern [128];
  logic [31:0] cursorTable [16];
  logic [CW-1:0] hCount, vCount;
  logic hSyncOn, vSyncOn, deOn, hSyncPrev, vSyncPrev;
  logic controllerOn, hEnd;
  lvt_bus_e busState;
  logic wrPend;
  logic [11:0] wrAddr, rdAddr;
  logic [31:0] statusWord, readWord;
  logic busTake;

  function automatic lvt_region_e regionOf(input logic [11:0] a);
    if (a[11:10] == 2'b01) begin
      regionOf = LVT_RG_GCLUT;
    end else if (a[11:9] == 3'b100) begin
      regionOf = LVT_RG_CURPAT;
    end else if (a[11:6] == 6'(`LVT_CURLUT_BASE >> 6)) begin
      regionOf = LVT_RG_CURLUT;
    end else begin
      case (a)
        `LVT_MODE_OFS: regionOf = LVT_RG_MODE;
        `LVT_RES_OFS: regionOf = LVT_RG_RES;
        `LVT_FRONT_OFS: regionOf = LVT_RG_FRONT;
        `LVT_BLANK_OFS: regionOf = LVT_RG_BLANK;
        `LVT_TOTAL_OFS: regionOf = LVT_RG_TOTAL;
        `LVT_IRQCTL_OFS: regionOf = LVT_RG_IRQCTL;
        `LVT_STATUS_OFS: regionOf = LVT_RG_STATUS;
        default: regionOf = LVT_RG_NONE;
      endcase
    end
  endfunction

  function automatic logic [31:0] packXY(input logic [CW-1:0] x, input logic [CW-1:0] y);
    packXY = 32'h00000000;
    packXY[`LVT_X_HI:`LVT_X_LO] = x;
    packXY[`LVT_Y_HI:`LVT_Y_LO] = y;
  endfunction

  assign controllerOn = modeReg[`LVT_MODE_ON_BIT];
  assign busTake = hsel & htrans[1] & hready;
  assign hresp = 1'b0;
  // Reads take one wait state so that read data leaves a flip-flop.
  assign hreadyout = (busState != LVT_BUS_RDWAIT);

  // Address phase capture and read sequencing.
  always_ff @(posedge mclk) begin
    if (reset) begin
      busState <= LVT_BUS_IDLE;
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
      rdAddr <= 12'h000;
    end else begin
      wrPend <= busTake & hwrite;
      if (busTake) begin
        wrAddr <= {haddr[11:2], 2'b00};
        rdAddr <= {haddr[11:2], 2'b00};
      end
      case (busState)
        LVT_BUS_IDLE: busState <= (busTake & ~hwrite) ? LVT_BUS_RDWAIT : LVT_BUS_IDLE;
        LVT_BUS_RDWAIT: busState <= LVT_BUS_RDDONE;
        LVT_BUS_RDDONE: busState <= (busTake & ~hwrite) ? LVT_BUS_RDWAIT : LVT_BUS_IDLE;
        default: busState <= LVT_BUS_IDLE;
      endcase
    end
  end

  // Control register writes; the status word has no storage behind it.
  always_ff @(posedge mclk) begin
    if (reset) begin
      modeReg <= `LVT_REG_RESET;
      irqCtl <= `LVT_REG_RESET;
      activeWidth <= '0;
      activeHeight <= '0;
      hFront <= '0;
      vFront <= '0;
      hBlank <= '0;
      vBlank <= '0;
      hTotal <= '0;
      vTotal <= '0;
    end else if (wrPend) begin
      case (regionOf(wrAddr))
        LVT_RG_MODE: modeReg <= hwdata & 32'h8000000F;
        LVT_RG_IRQCTL: irqCtl <= hwdata & 32'h80000003;
        LVT_RG_RES: begin
          activeWidth <= hwdata[`LVT_X_HI:`LVT_X_LO];
          activeHeight <= hwdata[`LVT_Y_HI:`LVT_Y_LO];
        end
        LVT_RG_FRONT: begin
          hFront <= hwdata[`LVT_X_HI:`LVT_X_LO];
          vFront <= hwdata[`LVT_Y_HI:`LVT_Y_LO];
        end
        LVT_RG_BLANK: begin
          hBlank <= hwdata[`LVT_X_HI:`LVT_X_LO];
          vBlank <= hwdata[`LVT_Y_HI:`LVT_Y_LO];
        end
        LVT_RG_TOTAL: begin
          hTotal <= hwdata[`LVT_X_HI:`LVT_X_LO];
          vTotal <= hwdata[`LVT_Y_HI:`LVT_Y_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // Table storage; the unused upper byte of colour words is never stored.
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        colorTable[i] <= `LVT_REG_RESET;
      end
      for (int i = 0; i < 128; i++) begin
        cursorPattern[i] <= `LVT_REG_RESET;
      end
      for (int i = 0; i < 16; i++) begin
        cursorTable[i] <= `LVT_REG_RESET;
      end
    end else if (wrPend) begin
      case (regionOf(wrAddr))
        LVT_RG_GCLUT: colorTable[wrAddr[9:2]] <= hwdata & `LVT_COLOR_MASK;
        LVT_RG_CURPAT: cursorPattern[wrAddr[8:2]] <= hwdata;
        LVT_RG_CURLUT: cursorTable[wrAddr[5:2]] <= hwdata & `LVT_COLOR_MASK;
        default: begin
        end
      endcase
    end
  end

  // reserved status bits zero
  // The status word looks at the counters, so its row flags lead the pins by one cycle.
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[`LVT_ST_FINAL_ROW_FLAG_BIT] = controllerOn & (vCount == activeHeight - 1'b1) & (vCount < activeHeight);
    statusWord[`LVT_ST_VSYNC_BIT] = panelPins.frameSync;
    statusWord[`LVT_ST_HSYNC_BIT] = panelPins.lineSync;
    statusWord[`LVT_ST_DE_BIT] = panelPins.dataEnable;
    statusWord[`LVT_ST_ACTIVE_BIT] = controllerOn & (vCount < activeHeight);
  end

  always_comb begin
    readWord = 32'h00000000;
    case (regionOf(rdAddr))
      LVT_RG_MODE: readWord = modeReg;
      LVT_RG_IRQCTL: readWord = irqCtl;
      LVT_RG_RES: readWord = packXY(activeWidth, activeHeight);
      LVT_RG_FRONT: readWord = packXY(hFront, vFront);
      LVT_RG_BLANK: readWord = packXY(hBlank, vBlank);
      LVT_RG_TOTAL: readWord = packXY(hTotal, vTotal);
      LVT_RG_STATUS: readWord = statusWord;
      LVT_RG_GCLUT: readWord = colorTable[rdAddr[9:2]];
      LVT_RG_CURPAT: readWord = cursorPattern[rdAddr[8:2]];
      LVT_RG_CURLUT: readWord = cursorTable[rdAddr[5:2]];
      default: readWord = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (busState == LVT_BUS_RDWAIT) begin
      hrdata <= readWord;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cursorPixel <= 4'h0;
    end else begin
      cursorPixel <= cursorPattern[{cursorY, cursorX[4:3]}][5'd31 - {cursorX[2:0], 2'b00} -: 4];
    end
  end

  // period is total pixels times total lines
  assign hEnd = (hCount == hTotal - 1'b1) | (hTotal == '0);

  always_ff @(posedge mclk) begin
    if (reset || !controllerOn) begin
      hCount <= '0;
      vCount <= '0;
    end else if (hEnd) begin
      hCount <= '0;
      vCount <= (vCount == vTotal - 1'b1 || vTotal == '0) ? '0 : vCount + 1'b1;
    end else begin
      hCount <= hCount + 1'b1;
    end
  end

  // syncs and enable from timing state
  always_ff @(posedge mclk) begin
    if (reset || !controllerOn) begin
      hSyncOn <= 1'b0;
      vSyncOn <= 1'b0;
      deOn <= 1'b0;
    end else begin
      // sync between front and blank thresholds
      hSyncOn <= (hCount >= hFront) && (hCount < hBlank);
      vSyncOn <= (vCount >= vFront) && (vCount < vBlank);
      deOn <= (hCount < activeWidth) && (vCount < activeHeight);
    end
  end

  // polarity shaping at the pins
  // A zero sync polarity means active low, so the idle level is high.
  assign panelPins = {
    vSyncOn ^ ~modeReg[`LVT_MODE_VPOL_BIT],
    hSyncOn ^ ~modeReg[`LVT_MODE_HPOL_BIT],
    deOn ^ modeReg[`LVT_MODE_DEPOL_BIT]
  };
  assign pixelClockInvert = modeReg[`LVT_MODE_PIXEL_CLOCK_POLARITY_BIT];

  always_ff @(posedge mclk) begin
    if (reset) begin
      hSyncPrev <= 1'b0;
      vSyncPrev <= 1'b0;
    end else begin
      hSyncPrev <= hSyncOn;
      vSyncPrev <= vSyncOn;
    end
  end

  always_comb begin
    if (irqCtl[`LVT_IRQ_TRIG_BIT]) begin
      lineIrq = irqCtl[`LVT_IRQ_HEN_BIT] & hSyncOn & ~hSyncPrev;
      frameIrq = irqCtl[`LVT_IRQ_VEN_BIT] & vSyncOn & ~vSyncPrev;
    end else begin
      lineIrq = irqCtl[`LVT_IRQ_HEN_BIT] & hSyncOn;
      frameIrq = irqCtl[`LVT_IRQ_VEN_BIT] & vSyncOn;
    end
  end

  edge_single_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    irqCtl[`LVT_IRQ_TRIG_BIT] && lineIrq |=> !lineIrq)
    else $error("line interrupt pulse longer than one cycle in edge mode");

  level_follows_sync_a: assert property (@(posedge mclk) disable iff (reset)
    !irqCtl[`LVT_IRQ_TRIG_BIT] && irqCtl[`LVT_IRQ_HEN_BIT] |-> (lineIrq == (panelPins.lineSync == modeReg[0])))
    else $error("level line interrupt does not follow line sync");

  frame_gate_off_a: assert property (@(posedge mclk) disable iff (reset)
    !irqCtl[`LVT_IRQ_VEN_BIT] |-> !frameIrq)
    else $error("frame interrupt raised while disabled");

  line_gate_off_a: assert property (@(posedge mclk) disable iff (reset)
    !irqCtl[`LVT_IRQ_HEN_BIT] |-> !lineIrq)
    else $error("line interrupt raised while disabled");

  status_reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
    busState == LVT_BUS_RDDONE && regionOf(rdAddr) == LVT_RG_STATUS |-> hrdata[31:6] == 26'h0 && !hrdata[4])
    else $error("reserved status bits read nonzero");

  de_in_active_a: assert property (@(posedge mclk) disable iff (reset)
    deOn |-> $past(hCount) < activeWidth && $past(vCount) < activeHeight)
    else $error("data enable outside the active area");

  pixel_wrap_a: assert property (@(posedge mclk) disable iff (reset)
    controllerOn && hTotal != '0 && hCount == hTotal - 1'b1 ##1 controllerOn |-> hCount == '0)
    else $error("pixel counter did not wrap after the total");

  line_step_a: assert property (@(posedge mclk) disable iff (reset)
    controllerOn && $past(controllerOn) && vCount != $past(vCount) |-> $past(hEnd))
    else $error("line counter moved inside a line");

  off_idle_pins_a: assert property (@(posedge mclk) disable iff (reset)
    !controllerOn |=> !controllerOn |-> !deOn && !hSyncOn && !vSyncOn && hCount == '0)
    else $error("timing runs while controller is off");

  status_levels_a: assert property (@(posedge mclk) disable iff (reset)
    statusWord[3:1] == {panelPins.frameSync, panelPins.lineSync, panelPins.dataEnable})
    else $error("status levels differ from pins");

  read_wait_a: assert property (@(posedge mclk) disable iff (reset)
    busTake && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  final_row_active_a: assert property (@(posedge mclk) disable iff (reset)
    statusWord[`LVT_ST_FINAL_ROW_FLAG_BIT] |-> statusWord[`LVT_ST_ACTIVE_BIT])
    else $error("final row flag set outside the active rows");

  blank_no_enable_a: assert property (@(posedge mclk) disable iff (reset)
    !statusWord[`LVT_ST_ACTIVE_BIT] |=> !deOn)
    else $error("data enable raised during vertical blanking");

  frame_edge_once_a: assert property (@(posedge mclk) disable iff (reset)
    irqCtl[`LVT_IRQ_TRIG_BIT] && frameIrq |=> !frameIrq)
    else $error("frame interrupt pulse longer than one cycle in edge mode");

  frame_level_follows_a: assert property (@(posedge mclk) disable iff (reset)
    !irqCtl[`LVT_IRQ_TRIG_BIT] && irqCtl[`LVT_IRQ_VEN_BIT] |->
      (frameIrq == (panelPins.frameSync == modeReg[`LVT_MODE_VPOL_BIT])))
    else $error("level frame interrupt does not follow frame sync");

  line_edge_rise_a: assert property (@(posedge mclk) disable iff (reset)
    irqCtl[`LVT_IRQ_TRIG_BIT] && lineIrq |-> $rose(hSyncOn))
    else $error("edge line interrupt without a line sync rise");

endmodule

// >>> rtl/lvt_map.svh
// Register offsets, field positions and reset values of the video timing block.
`ifndef LVT_MAP_SVH
`define LVT_MAP_SVH
`define LVT_MODE_OFS 12'h000
`define LVT_RES_OFS 12'h004
`define LVT_FRONT_OFS 12'h008
`define LVT_BLANK_OFS 12'h00C
`define LVT_TOTAL_OFS 12'h010
`define LVT_IRQCTL_OFS 12'h014
`define LVT_STATUS_OFS 12'h018
`define LVT_GCLUT_BASE 12'h400
`define LVT_CURPAT_BASE 12'h800
`define LVT_CURLUT_BASE 12'hA00
`define LVT_MODE_ON_BIT 31
`define LVT_MODE_PIXEL_CLOCK_POLARITY_BIT 3
`define LVT_MODE_DEPOL_BIT 2
`define LVT_MODE_VPOL_BIT 1
`define LVT_MODE_HPOL_BIT 0
`define LVT_IRQ_TRIG_BIT 31
`define LVT_IRQ_HEN_BIT 1
`define LVT_IRQ_VEN_BIT 0
`define LVT_ST_FINAL_ROW_FLAG_BIT 5
`define LVT_ST_VSYNC_BIT 3
`define LVT_ST_HSYNC_BIT 2
`define LVT_ST_DE_BIT 1
`define LVT_ST_ACTIVE_BIT 0
`define LVT_X_HI 26
`define LVT_X_LO 16
`define LVT_Y_HI 10
`define LVT_Y_LO 0
`define LVT_COLOR_MASK 32'h00FFFFFF
`define LVT_REG_RESET 32'h00000000
`endif

// >>> rtl/lvt_pkg.sv
// Types shared by the video timing block.
package lvt_pkg;
  typedef enum logic [1:0] {LVT_BUS_IDLE, LVT_BUS_RDWAIT, LVT_BUS_RDDONE} lvt_bus_e;
  typedef enum logic [3:0] {
    LVT_RG_MODE, LVT_RG_RES, LVT_RG_FRONT, LVT_RG_BLANK, LVT_RG_TOTAL,
    LVT_RG_IRQCTL, LVT_RG_STATUS, LVT_RG_GCLUT, LVT_RG_CURPAT, LVT_RG_CURLUT, LVT_RG_NONE
  } lvt_region_e;
  typedef struct packed {
    logic frameSync;
    logic lineSync;
    logic dataEnable;
  } lvt_sync_s;
endpackage

// >>> test/lvt_panel_model.sv
// Panel-side model that measures frame, data-enable and sync spans on the pins.
`timescale 1ns/1ps
module lvt_panel_model
  import lvt_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Panel pins
  input wire lvt_sync_s pins,
  // Measurements of the last whole frame
  output logic frameTick,
  output logic [15:0] frameLen,
  output logic [15:0] deCnt,
  output logic [15:0] lineLow,
  output logic [15:0] frameLow
);
  logic prevFrame = 1'b1;
  logic [15:0] aLen = 16'h0000;
  logic [15:0] aDe = 16'h0000;
  logic [15:0] aLine = 16'h0000;
  logic [15:0] aFrm = 16'h0000;
  wire logic fallEdge = prevFrame & ~pins.frameSync;
  // A frame runs from one falling frame sync to the next, so a whole window is one period.
  // frame span counts
  always @(posedge mclk) begin
    prevFrame <= pins.frameSync;
    frameTick <= fallEdge;
    if (fallEdge) begin
      frameLen <= aLen;
      deCnt <= aDe;
      lineLow <= aLine;
      frameLow <= aFrm;
      aLen <= 16'h0001;
      aDe <= {15'h0000, pins.dataEnable};
      aLine <= {15'h0000, ~pins.lineSync};
      aFrm <= 16'h0001;
    end else begin
      aLen <= aLen + 16'h0001;
      aDe <= aDe + {15'h0000, pins.dataEnable};
      aLine <= aLine + {15'h0000, ~pins.lineSync};
      aFrm <= aFrm + {15'h0000, ~pins.frameSync};
    end
  end
endmodule

// >>> test/tb_lcd_video_timing_status.sv
// Self-checking bench for the video timing block over AHB-Lite.
`timescale 1ns/1ps
`include "lvt_map.svh"
module tb_lcd_video_timing_status
  import lvt_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [4:0] cursorX = 5'h00;
  logic [4:0] cursorY = 5'h00;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pixelClockInvert, lineIrq, frameIrq;
  lvt_sync_s panelPins;
  logic [3:0] cursorPixel;
  logic frameTick;
  logic [15:0] frameLen, deCnt, lineLow, frameLow, nLI, nFI;
  logic [15:0] aLI = 16'h0000;
  logic [15:0] aFI = 16'h0000;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [31:0] base[3] = '{32'h00000400, 32'h00000800, 32'h00000A00};
  logic [31:0] mask[3] = '{`LVT_COLOR_MASK, 32'hFFFFFFFF, `LVT_COLOR_MASK};
  int last[3] = '{255, 127, 15};
  logic rdData = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 79261;

  lcd_video_timing_status dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .panelPins(panelPins), .pixelClockInvert(pixelClockInvert),
    .lineIrq(lineIrq), .frameIrq(frameIrq), .cursorX(cursorX), .cursorY(cursorY),
    .cursorPixel(cursorPixel));
  lvt_panel_model panel (.mclk(mclk), .pins(panelPins), .frameTick(frameTick), .frameLen(frameLen),
    .deCnt(deCnt), .lineLow(lineLow), .frameLow(frameLow));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // Read data is judged at the edge that ends the data phase.
  always @(posedge mclk) begin
    if (rdData && hreadyout === 1'b1) begin
      check("read data", hrdata & mskQ.pop_front(), expQ.pop_front());
      check("response", {31'h00000000, hresp}, 32'h00000000);
    end
    if (hreadyout === 1'b1)
      rdData = hsel & htrans[1] & ~hwrite;
  end

  always @(posedge mclk) begin
    if (frameTick === 1'b1) begin
      nLI <= aLI;
      nFI <= aFI;
      aLI <= {15'h0000, lineIrq};
      aFI <= {15'h0000, frameIrq};
    end else begin
      aLI <= aLI + {15'h0000, lineIrq};
      aFI <= aFI + {15'h0000, frameIrq};
    end
  end

  task automatic busOp(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    busOp(1'b0, a, 32'h00000000);
  endtask

  // Timing is 4 of 10 pixels and 3 of 6 lines, so one frame lasts 60 cycles.
  task automatic frameCheck(input logic [15:0] eLI, input logic [15:0] eFI);
    repeat (160) @(posedge mclk);
    check("frame length", {16'h0000, frameLen}, 32'h0000003C);
    check("enable cycles", {16'h0000, deCnt}, 32'h0000000C);
    check("line sync cycles", {16'h0000, lineLow}, 32'h0000000C);
    check("frame sync cycles", {16'h0000, frameLow}, 32'h0000000A);
    check("line irq cycles", {16'h0000, nLI}, {16'h0000, eLI});
    check("frame irq cycles", {16'h0000, nFI}, {16'h0000, eFI});
  endtask

  initial begin
    logic [31:0] a;
    logic [31:0] v;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(`LVT_STATUS_OFS, 32'h0000000C, 32'hFFFFFFFF);
    rd(`LVT_IRQCTL_OFS, 32'h00000000, 32'hFFFFFFFF);
    busOp(1'b1, `LVT_IRQCTL_OFS, 32'hFFFFFFFF);
    rd(`LVT_IRQCTL_OFS, 32'h80000003, 32'hFFFFFFFF);
    busOp(1'b1, `LVT_STATUS_OFS, 32'hFFFFFFFF);
    rd(`LVT_STATUS_OFS, 32'h0000000C, 32'hFFFFFFFF);
    rd(32'h00000100, 32'h00000000, 32'hFFFFFFFF);
    rd(32'h00000A40, 32'h00000000, 32'hFFFFFFFF);
    for (int t = 0; t < 3; t++) begin
      for (int k = 0; k < 2; k++) begin
        a = base[t] + (k * last[t] * 4);
        v = $random(seed);
        busOp(1'b1, a, v);
        rd(a, v & mask[t], 32'hFFFFFFFF);
      end
    end
    $display("register tests done");
    busOp(1'b1, `LVT_CURPAT_BASE + 92, 32'hFEDCBA98);
    cursorY <= 5'd5;
    cursorX <= 5'd29;
    repeat (2) @(posedge mclk);
    check("cursor pixel", {28'h0000000, cursorPixel}, 32'h0000000A);
    $display("cursor test done");
    busOp(1'b1, `LVT_RES_OFS, 32'h00040003);
    busOp(1'b1, `LVT_FRONT_OFS, 32'h00060004);
    busOp(1'b1, `LVT_BLANK_OFS, 32'h00080005);
    busOp(1'b1, `LVT_TOTAL_OFS, 32'h000A0006);
    busOp(1'b1, `LVT_IRQCTL_OFS, 32'h00000000);
    busOp(1'b1, `LVT_MODE_OFS, 32'h80000000);
    frameCheck(16'h0000, 16'h0000);
    rd(`LVT_STATUS_OFS, 32'h00000000, 32'hFFFFFFD0);
    // Reads aligned to the frame tick sample frame cycle 45 (frame sync) and cycle 23 (final row).
    do @(posedge mclk); while (frameTick !== 1'b1);
    rd(`LVT_STATUS_OFS, 32'h00000004, 32'hFFFFFFFF);
    do @(posedge mclk); while (frameTick !== 1'b1);
    repeat (38) @(posedge mclk);
    rd(`LVT_STATUS_OFS, 32'h0000002F, 32'hFFFFFFFF);
    busOp(1'b1, `LVT_IRQCTL_OFS, 32'h00000003);
    frameCheck(16'h000C, 16'h000A);
    busOp(1'b1, `LVT_IRQCTL_OFS, 32'h80000003);
    frameCheck(16'h0006, 16'h0001);
    busOp(1'b1, `LVT_IRQCTL_OFS, 32'h80000002);
    frameCheck(16'h0006, 16'h0000);
    $display("timing tests done");
    busOp(1'b1, `LVT_MODE_OFS, 32'h0000000F);
    repeat (3) @(posedge mclk);
    check("idle pins", {29'h00000000, panelPins}, 32'h00000001);
    check("clock invert", {31'h00000000, pixelClockInvert}, 32'h00000001);
    rd(`LVT_STATUS_OFS, 32'h00000002, 32'hFFFFFFFF);
    repeat (3) @(posedge mclk);
    $display("polarity test done");
    close_out();
  end
endmodule
